/* blle_exec.sv */
// Execution unit for short branches, jumps, counted loops and loads.
// Assumes an AXI4-Lite master on aclk; memory operands are staged by
// software in the operand registers before a command is written.
`timescale 1ns/100ps

module blle_exec
  import blle_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic [2:0] awprot,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic [2:0] arprot,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  output logic bus_lock
);

  typedef struct packed {
    blle_state_type state;
    logic awready;
    logic wready;
    logic arready;
    logic aw_ok;
    logic [7:0] aw_addr;
    logic w_ok;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic bvalid;
    logic [1:0] bresp;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
    blle_arch_type arch;
    blle_cmd_type cmd;
    logic taken;
    logic bus_lock;
  } blle_st_type;

  blle_st_type r;
  blle_st_type next_r;

  // Byte-lane merge of a 16-bit register
  function automatic logic [15:0] merge16(input logic [15:0] old,
                                          input logic [31:0] d,
                                          input logic [3:0] s);
    merge16 = old;
    if (s[0]) merge16[7:0] = d[7:0];
    if (s[1]) merge16[15:8] = d[15:8];
  endfunction

  // Sign extension of the short displacement
  function automatic logic [15:0] sext8(input logic [7:0] d);
    sext8 = {{8{d[7]}}, d};
  endfunction

  // Read decode; the bool flags whether the address maps
  function automatic logic [32:0] read_reg(input logic [7:0] a,
                                           input blle_st_type s);
    logic [15:0] v;
    logic hit;
    v = 16'h0000;
    hit = 1'b1;
    if (a == OFF_CMD) v = {s.cmd.short_displacement, 2'h0, s.cmd.op};
    else if (a == OFF_FLAGS) v = s.arch.flags;
    else if (a == OFF_IP) v = s.arch.instr_pointer;
    else if (a == OFF_CS) v = s.arch.code_segment_reg;
    else if (a == OFF_DS) v = s.arch.data_segment_reg;
    else if (a == OFF_ES) v = s.arch.extra_segment_reg;
    else if (a == OFF_AX) v = s.arch.accumulator_word;
    else if (a == OFF_CX) v = s.arch.count_reg;
    else if (a == OFF_BP) v = s.arch.frame_base_reg;
    else if (a == OFF_SP) v = s.arch.stack_pointer_reg;
    else if (a == OFF_SI) v = s.arch.source_index_reg;
    else if (a == OFF_DEST) v = s.arch.dest_reg;
    else if (a == OFF_MEM_LO) v = s.arch.mem_lo;
    else if (a == OFF_MEM_HI) v = s.arch.mem_hi;
    else if (a == OFF_EA) v = s.arch.effective_address;
    else if (a == OFF_STATUS) v = {10'h000, s.cmd.repeat_prefix, s.cmd.seg_prefix,
                                   s.cmd.lock_prefix, s.state == ST_EXEC,
                                   s.bus_lock, s.taken};
    else hit = 1'b0;
    read_reg = {hit, 16'h0000, v};
  endfunction

  // Next-state logic: bus slave plus the single execute cycle
  always_comb begin
    blle_arch_type a;
    logic [32:0] rd;
    logic [15:0] new_cx;
    logic [15:0] step;
    logic take;
    next_r = r;
    a = r.arch;
    rd = 33'h000000000;
    new_cx = 16'(r.arch.count_reg - 16'h0001);
    step = r.cmd.word ? STEP_WORD : STEP_BYTE;
    take = 1'b0;

    // Address and data are taken in either order
    if (awvalid && r.awready) begin
      next_r.aw_ok = 1'b1;
      next_r.aw_addr = {awaddr[7:2], 2'h0};
    end
    if (wvalid && r.wready) begin
      next_r.w_ok = 1'b1;
      next_r.w_data = wdata;
      next_r.w_strb = wstrb;
    end
    if (bvalid && bready) begin
      next_r.bvalid = 1'b0;
    end

    // Execute one instruction; flags are never written here
    if (r.state == ST_EXEC) begin
      case (blle_op_type'(r.cmd.op))
        OP_BRANCH_IF_LESS, OP_BRANCH_IF_NOT_GREATER_EQUAL: begin
          take = a.flags[FLAG_SIGN] != a.flags[FLAG_OVF];
        end
        OP_BRANCH_IF_LESS_EQUAL, OP_BRANCH_IF_NOT_GREATER: begin
          take = (a.flags[FLAG_SIGN] != a.flags[FLAG_OVF])
                 || a.flags[FLAG_ZERO];
        end
        OP_BRANCH_IF_NO_CARRY: take = !a.flags[FLAG_CARRY];
        OP_BRANCH_IF_NOT_EQUAL, OP_BRANCH_IF_NONZERO: take = !a.flags[FLAG_ZERO];
        OP_BRANCH_IF_NO_OVERFLOW: take = !a.flags[FLAG_OVF];
        OP_BRANCH_IF_NOT_NEGATIVE: take = !a.flags[FLAG_SIGN];
        OP_BRANCH_IF_NO_PARITY, OP_BRANCH_IF_PARITY_ODD: begin
          take = !a.flags[FLAG_PARITY];
        end
        OP_BRANCH_IF_OVERFLOW: take = a.flags[FLAG_OVF];
        OP_BRANCH_IF_PARITY, OP_BRANCH_IF_PARITY_EVEN: begin
          take = a.flags[FLAG_PARITY];
        end
        OP_BRANCH_IF_NEGATIVE: take = a.flags[FLAG_SIGN];
        OP_JUMP_SHORT: take = 1'b1;
        OP_JUMP_NEAR: begin
          next_r.arch.instr_pointer = 16'(a.instr_pointer + a.effective_address);
        end
        OP_JUMP_FAR: begin
          next_r.arch.code_segment_reg = a.mem_hi;
          next_r.arch.instr_pointer = a.effective_address;
        end
        OP_JUMP_MEM: next_r.arch.instr_pointer = a.mem_lo;
        OP_JUMP_REG: next_r.arch.instr_pointer = a.dest_reg;
        OP_FLAGS_TO_HIGH_ACC: begin
          // Undefined positions 5, 3 and 1 are driven low
          next_r.arch.accumulator_word[15:8] = {a.flags[FLAG_SIGN],
            a.flags[FLAG_ZERO], 1'b0, a.flags[FLAG_AUX], 1'b0,
            a.flags[FLAG_PARITY], 1'b0, a.flags[FLAG_CARRY]};
        end
        OP_FAR_PTR_LOAD_DATA_SEG: begin
          next_r.arch.dest_reg = a.mem_lo;
          next_r.arch.data_segment_reg = a.mem_hi;
        end
        OP_FAR_PTR_LOAD_EXTRA_SEG: begin
          next_r.arch.dest_reg = a.mem_lo;
          next_r.arch.extra_segment_reg = a.mem_hi;
        end
        OP_OFFSET_LOAD: next_r.arch.dest_reg = a.effective_address;
        OP_FRAME_TEARDOWN: begin
          // Old frame base is the popped word staged at the frame base
          next_r.arch.stack_pointer_reg = 16'(a.frame_base_reg + POP_STEP);
          next_r.arch.frame_base_reg = a.mem_lo;
        end
        OP_STRING_LOAD: begin
          if (r.cmd.word) next_r.arch.accumulator_word = a.mem_lo;
          else next_r.arch.accumulator_word[7:0] = a.mem_lo[7:0];
          if (!a.flags[FLAG_DIR]) next_r.arch.source_index_reg = 16'(a.source_index_reg + step);
          else next_r.arch.source_index_reg = 16'(a.source_index_reg - step);
        end
        OP_COUNT_BRANCH: begin
          next_r.arch.count_reg = new_cx;
          take = new_cx != 16'h0000;
        end
        OP_COUNT_BRANCH_WHILE_ZERO, OP_COUNT_BRANCH_WHILE_ZERO_ALIAS: begin
          next_r.arch.count_reg = new_cx;
          take = (new_cx != 16'h0000) && a.flags[FLAG_ZERO];
        end
        default: take = 1'b0;
      endcase
      // Fall-through leaves the pointer as staged by software
      if (take) begin
        next_r.arch.instr_pointer = 16'(a.instr_pointer
                                        + sext8(r.cmd.short_displacement));
      end
      next_r.taken = take || (blle_op_type'(r.cmd.op) inside
                     {OP_JUMP_NEAR, OP_JUMP_FAR, OP_JUMP_MEM, OP_JUMP_REG});
      next_r.state = ST_IDLE;
    end

    // Register write once both halves are in; blocked while executing
    if (r.aw_ok && r.w_ok && !r.bvalid && r.state == ST_IDLE) begin
      next_r.aw_ok = 1'b0;
      next_r.w_ok = 1'b0;
      next_r.bvalid = 1'b1;
      next_r.bresp = RESP_OKAY;
      if (r.aw_addr == OFF_CMD) begin
        // Prefix bits may be combined freely
        next_r.cmd = merge32_cmd(r.cmd, r.w_data, r.w_strb);
        next_r.state = ST_EXEC;
      end
      else if (r.aw_addr == OFF_FLAGS) next_r.arch.flags = merge16(a.flags, r.w_data, r.w_strb);
      else if (r.aw_addr == OFF_IP) begin
        next_r.arch.instr_pointer = merge16(a.instr_pointer, r.w_data, r.w_strb);
      end
      else if (r.aw_addr == OFF_CS) begin
        next_r.arch.code_segment_reg = merge16(a.code_segment_reg, r.w_data, r.w_strb);
      end
      else if (r.aw_addr == OFF_DS) begin
        next_r.arch.data_segment_reg = merge16(a.data_segment_reg, r.w_data, r.w_strb);
      end
      else if (r.aw_addr == OFF_ES) begin
        next_r.arch.extra_segment_reg = merge16(a.extra_segment_reg, r.w_data, r.w_strb);
      end
      else if (r.aw_addr == OFF_AX) begin
        next_r.arch.accumulator_word = merge16(a.accumulator_word, r.w_data, r.w_strb);
      end
      else if (r.aw_addr == OFF_CX) begin
        next_r.arch.count_reg = merge16(a.count_reg, r.w_data, r.w_strb);
      end
      else if (r.aw_addr == OFF_BP) begin
        next_r.arch.frame_base_reg = merge16(a.frame_base_reg, r.w_data, r.w_strb);
      end
      else if (r.aw_addr == OFF_SP) begin
        next_r.arch.stack_pointer_reg = merge16(a.stack_pointer_reg, r.w_data, r.w_strb);
      end
      else if (r.aw_addr == OFF_SI) begin
        next_r.arch.source_index_reg = merge16(a.source_index_reg, r.w_data, r.w_strb);
      end
      else if (r.aw_addr == OFF_DEST) begin
        next_r.arch.dest_reg = merge16(a.dest_reg, r.w_data, r.w_strb);
      end
      else if (r.aw_addr == OFF_MEM_LO) begin
        next_r.arch.mem_lo = merge16(a.mem_lo, r.w_data, r.w_strb);
      end
      else if (r.aw_addr == OFF_MEM_HI) begin
        next_r.arch.mem_hi = merge16(a.mem_hi, r.w_data, r.w_strb);
      end
      else if (r.aw_addr == OFF_EA) begin
        next_r.arch.effective_address = merge16(a.effective_address, r.w_data, r.w_strb);
      end
      else if (r.aw_addr != OFF_STATUS) next_r.bresp = RESP_SLVERR;
    end

    // Read channel: one read under way at a time
    if (arvalid && r.arready) begin
      rd = read_reg({araddr[7:2], 2'h0}, r);
      next_r.rvalid = 1'b1;
      next_r.rdata = rd[31:0];
      next_r.rresp = rd[32] ? RESP_OKAY : RESP_SLVERR;
      next_r.arready = 1'b0;
    end
    else if (r.rvalid && rready) begin
      next_r.rvalid = 1'b0;
      next_r.arready = 1'b1;
    end

    // Ready flags held in flops so outputs stay registered
    next_r.awready = !next_r.aw_ok;
    next_r.wready = !next_r.w_ok;
    // Lock spans exactly the execute cycle of the prefixed instruction
    next_r.bus_lock = (next_r.state == ST_EXEC) && next_r.cmd.lock_prefix;
  end

  // Merge in register layout, then unpack; the struct keeps the register's field order but drops its unused bits
  function automatic blle_cmd_type merge32_cmd(input blle_cmd_type old,
                                               input logic [31:0] d,
                                               input logic [3:0] s);
    logic [23:0] v;
    v = {4'h0, old.repeat_prefix, old.seg_prefix, old.lock_prefix, old.word,
         old.short_displacement, 2'h0, old.op};
    if (s[0]) v[7:0] = d[7:0];
    if (s[1]) v[15:8] = d[15:8];
    if (s[2]) v[23:16] = d[23:16];
    merge32_cmd = {v[CMD_REP_BIT], v[CMD_SEG_BIT], v[CMD_LOCK_BIT], v[CMD_WORD_BIT],
                   v[CMD_DISP_LSB +: 8], v[CMD_OP_LSB +: 6]};
  endfunction

  // State register, synchronous reset
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      r <= '{state: ST_IDLE, awready: 1'b1, wready: 1'b1, arready: 1'b1,
             default: '0};
    end
    else begin
      r <= next_r;
    end
  end

  assign awready = r.awready;
  assign wready = r.wready;
  assign bvalid = r.bvalid;
  assign bresp = r.bresp;
  assign arready = r.arready;
  assign rvalid = r.rvalid;
  assign rdata = r.rdata;
  assign rresp = r.rresp;
  assign bus_lock = r.bus_lock;

endmodule // blle_exec

/* blle_exec_monitor.sv */
// Checker for the register port and bus lock output of the execution block.
// Assumes it is bound onto blle_exec; one clock, synchronous active-low reset.
`timescale 1ns/100ps
module blle_exec_monitor
  import blle_pkg::*;
(
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  input wire logic awready,
  input wire logic [31:0] wdata,
  input wire logic wvalid,
  input wire logic wready,
  input wire logic [1:0] bresp,
  input wire logic bvalid,
  input wire logic bready,
  input wire logic arvalid,
  input wire logic arready,
  input wire logic [31:0] rdata,
  input wire logic [1:0] rresp,
  input wire logic rvalid,
  input wire logic rready,
  input wire logic bus_lock
);
  // One domain, so clock and reset are given once
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  // Responses stand until the master takes them
  property p_b_hold; bvalid && !bready |=> bvalid && $stable(bresp); endproperty
  a_b_hold: assert property (p_b_hold) else $error("bvalid dropped early");
  property p_r_hold; rvalid && !rready |=> rvalid && $stable(rdata); endproperty
  a_r_hold: assert property (p_r_hold) else $error("rvalid dropped early");
  // Answers arrive in the promised cycles; write response one or two cycles on, read data one
  property p_b_ans; awvalid && awready && wvalid && wready && !bvalid |-> ##[1:2] bvalid; endproperty
  a_b_ans: assert property (p_b_ans) else $error("write response late");
  property p_r_ans; arvalid && arready |=> rvalid; endproperty
  a_r_ans: assert property (p_r_ans) else $error("read data late");
  property p_b_end; bvalid && bready |=> !bvalid; endproperty
  a_b_end: assert property (p_b_end) else $error("bvalid stuck");
  property p_r_end; rvalid && rready |=> !rvalid && arready; endproperty
  a_r_end: assert property (p_r_end) else $error("read not closed");
  // Registers are 16 bits wide, so the upper half reads zero
  property p_r_hi; rvalid |-> rdata[31:16] == 16'h0000; endproperty
  a_r_hi: assert property (p_r_hi) else $error("read upper half set");
  // Lock covers one execute cycle and follows a locked command
  property p_lock_one; $rose(bus_lock) |=> !bus_lock; endproperty
  a_lock_one: assert property (p_lock_one) else $error("lock too long");
  property p_lock_cmd; awvalid && awready && wvalid && wready && awaddr == OFF_CMD
    && wdata[CMD_LOCK_BIT] |-> ##[1:5] bus_lock; endproperty
  a_lock_cmd: assert property (p_lock_cmd) else $error("lock missing");
endmodule // blle_exec_monitor

bind blle_exec blle_exec_monitor u_blle_exec_monitor (.aclk(aclk), .aresetn(aresetn),
  .awaddr(awaddr), .awvalid(awvalid), .awready(awready), .wdata(wdata), .wvalid(wvalid),
  .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .arvalid(arvalid),
  .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready),
  .bus_lock(bus_lock));

/* blle_pkg.sv */
// Package for the branch, loop and load execution block.
// Assumes a single 100 MHz core clock and an AXI4-Lite register port.
package blle_pkg;

  // Register byte offsets
  localparam logic [7:0] OFF_CMD = 8'h00;
  localparam logic [7:0] OFF_FLAGS = 8'h04;
  localparam logic [7:0] OFF_IP = 8'h08;
  localparam logic [7:0] OFF_CS = 8'h0C;
  localparam logic [7:0] OFF_DS = 8'h10;
  localparam logic [7:0] OFF_ES = 8'h14;
  localparam logic [7:0] OFF_AX = 8'h18;
  localparam logic [7:0] OFF_CX = 8'h1C;
  localparam logic [7:0] OFF_BP = 8'h20;
  localparam logic [7:0] OFF_SP = 8'h24;
  localparam logic [7:0] OFF_SI = 8'h28;
  localparam logic [7:0] OFF_DEST = 8'h2C;
  localparam logic [7:0] OFF_MEM_LO = 8'h30;
  localparam logic [7:0] OFF_MEM_HI = 8'h34;
  localparam logic [7:0] OFF_EA = 8'h38;
  localparam logic [7:0] OFF_STATUS = 8'h3C;

  // Flag positions in the flags register
  localparam int FLAG_CARRY = 0;
  localparam int FLAG_PARITY = 2;
  localparam int FLAG_AUX = 4;
  localparam int FLAG_ZERO = 6;
  localparam int FLAG_SIGN = 7;
  localparam int FLAG_DIR = 10;
  localparam int FLAG_OVF = 11;

  // Command register fields
  localparam int CMD_OP_LSB = 0;
  localparam int CMD_DISP_LSB = 8;
  localparam int CMD_WORD_BIT = 16;
  localparam int CMD_LOCK_BIT = 17;
  localparam int CMD_SEG_BIT = 18;
  localparam int CMD_REP_BIT = 19;

  // String pointer steps and stack pop step
  localparam logic [15:0] STEP_BYTE = 16'h0001;
  localparam logic [15:0] STEP_WORD = 16'h0002;
  localparam logic [15:0] POP_STEP = 16'h0002;

  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // Operation codes, numbered in this order from zero
  typedef enum logic [5:0] {
    OP_NOP, OP_BRANCH_IF_LESS, OP_BRANCH_IF_NOT_GREATER_EQUAL,
    OP_BRANCH_IF_LESS_EQUAL, OP_BRANCH_IF_NOT_GREATER,
    OP_JUMP_SHORT, OP_JUMP_NEAR, OP_JUMP_FAR, OP_JUMP_MEM, OP_JUMP_REG,
    OP_BRANCH_IF_NO_CARRY, OP_BRANCH_IF_NOT_EQUAL, OP_BRANCH_IF_NONZERO,
    OP_BRANCH_IF_NO_OVERFLOW, OP_BRANCH_IF_NOT_NEGATIVE,
    OP_BRANCH_IF_NO_PARITY, OP_BRANCH_IF_PARITY_ODD,
    OP_BRANCH_IF_OVERFLOW, OP_BRANCH_IF_PARITY, OP_BRANCH_IF_PARITY_EVEN,
    OP_BRANCH_IF_NEGATIVE, OP_FLAGS_TO_HIGH_ACC,
    OP_FAR_PTR_LOAD_DATA_SEG, OP_FAR_PTR_LOAD_EXTRA_SEG, OP_OFFSET_LOAD,
    OP_FRAME_TEARDOWN, OP_STRING_LOAD, OP_COUNT_BRANCH,
    OP_COUNT_BRANCH_WHILE_ZERO, OP_COUNT_BRANCH_WHILE_ZERO_ALIAS
  } blle_op_type;

  typedef enum {ST_IDLE, ST_EXEC} blle_state_type;

  // Architectural state seen by software
  typedef struct packed {
    logic [15:0] flags;
    logic [15:0] instr_pointer;
    logic [15:0] code_segment_reg;
    logic [15:0] data_segment_reg;
    logic [15:0] extra_segment_reg;
    logic [15:0] accumulator_word;
    logic [15:0] count_reg;
    logic [15:0] frame_base_reg;
    logic [15:0] stack_pointer_reg;
    logic [15:0] source_index_reg;
    logic [15:0] dest_reg;
    logic [15:0] mem_lo;
    logic [15:0] mem_hi;
    logic [15:0] effective_address;
  } blle_arch_type;

  // Latched command
  typedef struct packed {
    logic repeat_prefix;
    logic seg_prefix;
    logic lock_prefix;
    logic word;
    logic [7:0] short_displacement;
    logic [5:0] op;
  } blle_cmd_type;

endpackage

/* testbench.sv */
// Self-checking bench for the branch, loop and load execution block.
// Assumes blle_exec with its AXI4-Lite port; the checker binds itself.
`timescale 1ns/100ps
module testbench
  import blle_pkg::*;
;
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic slow = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rdata, rd_data;
  logic awready, wready, bvalid, arready, rvalid, bus_lock;
  logic [1:0] bresp, rresp, last_resp;
  int n_fail = 0, tests_run = 0, cyc = 0, lock_cnt = 0, n;

  blle_exec u_blle_exec (.aclk(aclk), .aresetn(aresetn), .awaddr(awaddr), .awprot(3'h0),
    .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(4'hF), .wvalid(wvalid),
    .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
    .arprot(3'h0), .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp),
    .rvalid(rvalid), .rready(rready), .bus_lock(bus_lock));

  // 100 MHz clock
  always #5 aclk = ~aclk;

  // Hang guard; also tallies cycles with the lock raised
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    lock_cnt <= lock_cnt + (bus_lock === 1'h1);
    if (cyc == 40000) begin
      n_fail = n_fail + 1;
      stop_test();
    end
  end

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run = tests_run + 1;
    if (got !== exp) begin
      n_fail = n_fail + 1;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  // One bus transfer; with slow set the master answers late
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
    logic done;
    done = 1'h0;
    @(posedge aclk);
    awaddr <= a;
    araddr <= a;
    wdata <= d;
    awvalid <= w;
    wvalid <= w;
    arvalid <= !w;
    bready <= w && !slow;
    rready <= !w && !slow;
    while (!done) begin
      @(posedge aclk);
      if (awready) awvalid <= 1'h0;
      if (wready) wvalid <= 1'h0;
      if (arready) arvalid <= 1'h0;
      done = (bvalid && bready) || (rvalid && rready);
      if (done) begin
        rd_data = rdata;
        last_resp = w ? bresp : rresp;
        bready <= 1'h0;
        rready <= 1'h0;
      end else if (bvalid || rvalid) begin
        bready <= w;
        rready <= !w;
      end
    end
  endtask

  task automatic setr(input logic [7:0] a, input logic [15:0] v);
    xfer(1'h1, a, {16'h0000, v});
  endtask

  task automatic chkr(input logic [7:0] a, input logic [15:0] e);
    xfer(1'h0, a, 32'h0);
    chk(rd_data, {16'h0000, e});
  endtask

  // Issue a command, then poll until the executing bit drops
  task automatic run(input logic [5:0] op, input logic [7:0] dsp, input logic [3:0] pre);
    xfer(1'h1, OFF_CMD, {12'h000, pre, dsp, 2'h0, op});
    repeat (2) @(posedge aclk);
    for (int i = 0; i < 8; i++) begin
      xfer(1'h0, OFF_STATUS, 32'h0);
      if (rd_data[2] === 1'h0) break;
    end
  endtask

  // Set one register, run a command, read one result back
  task automatic step(input logic [7:0] sa, input logic [15:0] sv, input logic [5:0] op,
                      input logic [3:0] pre, input logic [7:0] ca, input logic [15:0] ce);
    setr(sa, sv);
    run(op, 8'h00, pre);
    chkr(ca, ce);
  endtask

  // Expected decision from the flag word, op codes as numbered
  function automatic logic cond(input logic [5:0] o, input logic [15:0] f);
    case (o)
      6'h01, 6'h02: return f[FLAG_SIGN] != f[FLAG_OVF];
      6'h03, 6'h04: return f[FLAG_SIGN] != f[FLAG_OVF] || f[FLAG_ZERO];
      6'h0A: return !f[FLAG_CARRY];
      6'h0B, 6'h0C: return !f[FLAG_ZERO];
      6'h0D: return !f[FLAG_OVF];
      6'h0E: return !f[FLAG_SIGN];
      6'h0F, 6'h10: return !f[FLAG_PARITY];
      6'h11: return f[FLAG_OVF];
      6'h12, 6'h13: return f[FLAG_PARITY];
      default: return f[FLAG_SIGN];
    endcase
  endfunction

  // Reset values, unmapped places, late master, read-only status
  task automatic t_bus();
    chkr(OFF_IP, 16'h0000);
    slow = 1'h1;
    xfer(1'h0, 8'h40, 32'h0);
    chk({30'h0, last_resp}, {30'h0, RESP_SLVERR});
    chk(rd_data, 32'h0);
    xfer(1'h1, 8'h44, 32'h1);
    chk({30'h0, last_resp}, {30'h0, RESP_SLVERR});
    xfer(1'h1, OFF_STATUS, 32'hFF);
    chk({30'h0, last_resp}, {30'h0, RESP_OKAY});
    slow = 1'h0;
    chkr(OFF_STATUS, 16'h0000);
    $display("bus test done");
  endtask

  // Every conditional branch against several flag words, then jumps
  task automatic t_branch();
    logic [15:0] fl [5] = '{16'h0000, 16'h08C5, 16'h0080, 16'h0800, 16'h0040};
    for (int o = 1; o <= 20; o++) begin
      if (o > 4 && o < 10) continue;
      foreach (fl[j]) begin
        setr(OFF_FLAGS, fl[j]);
        setr(OFF_IP, 16'h1000);
        run(6'(o), 8'hF0, 4'h0);
        chkr(OFF_IP, cond(6'(o), fl[j]) ? 16'h0FF0 : 16'h1000);
        chkr(OFF_FLAGS, fl[j]);
      end
    end
    setr(OFF_IP, 16'h1000);
    run(OP_JUMP_SHORT, 8'h7F, 4'h0);
    chkr(OFF_IP, 16'h107F);
    step(OFF_EA, 16'h0200, OP_JUMP_NEAR, 4'h0, OFF_IP, 16'h127F);
    step(OFF_MEM_HI, 16'hC000, OP_JUMP_FAR, 4'h0, OFF_IP, 16'h0200);
    chkr(OFF_CS, 16'hC000);
    step(OFF_MEM_LO, 16'h4444, OP_JUMP_MEM, 4'h0, OFF_IP, 16'h4444);
    step(OFF_DEST, 16'h5555, OP_JUMP_REG, 4'h0, OFF_IP, 16'h5555);
    $display("branch test done");
  endtask

  // Flag copy, pointer loads, frame teardown, string loads
  task automatic t_data();
    setr(OFF_AX, 16'h0034);
    step(OFF_FLAGS, 16'h0CFF, OP_FLAGS_TO_HIGH_ACC, 4'h0, OFF_AX, 16'hD534);
    step(OFF_FLAGS, 16'h0014, OP_FLAGS_TO_HIGH_ACC, 4'h0, OFF_AX, 16'h1434);
    setr(OFF_EA, 16'h1234);
    setr(OFF_MEM_HI, 16'h5555);
    step(OFF_MEM_LO, 16'hAAAA, OP_FAR_PTR_LOAD_DATA_SEG, 4'h0,
         OFF_DEST, 16'hAAAA);
    chkr(OFF_DS, 16'h5555);
    step(OFF_MEM_LO, 16'h6666, OP_FAR_PTR_LOAD_EXTRA_SEG, 4'h0,
         OFF_DEST, 16'h6666);
    chkr(OFF_ES, 16'h5555);
    step(OFF_MEM_LO, 16'h7777, OP_OFFSET_LOAD, 4'h0, OFF_DEST, 16'h1234);
    setr(OFF_SP, 16'h7FFE);
    step(OFF_BP, 16'h2000, OP_FRAME_TEARDOWN, 4'h0, OFF_SP, 16'h2002);
    chkr(OFF_BP, 16'h7777);
    setr(OFF_SI, 16'h0100);
    setr(OFF_AX, 16'hAB00);
    step(OFF_FLAGS, 16'h0000, OP_STRING_LOAD, 4'h0, OFF_AX, 16'hAB77);
    chkr(OFF_SI, 16'h0101);
    step(OFF_FLAGS, 16'h0400, OP_STRING_LOAD, 4'h1, OFF_AX, 16'h7777);
    chkr(OFF_SI, 16'h00FF);
    chkr(OFF_FLAGS, 16'h0400);
    $display("data test done");
  endtask

  // One counted loop step: count falls by one, branch by 0x10 if taken
  task automatic lp(input logic [5:0] op, input logic [15:0] f, input logic [15:0] cx,
                    input logic tk);
    setr(OFF_FLAGS, f);
    setr(OFF_IP, 16'h1000);
    setr(OFF_CX, cx);
    run(op, 8'h10, 4'h0);
    chkr(OFF_CX, cx - 16'h0001);
    chkr(OFF_IP, tk ? 16'h1010 : 16'h1000);
  endtask

  task automatic t_loop();
    lp(OP_COUNT_BRANCH, 16'h0000, 16'h0002, 1'h1);
    lp(OP_COUNT_BRANCH, 16'h0040, 16'h0001, 1'h0);
    lp(OP_COUNT_BRANCH, 16'h0000, 16'h0000, 1'h1);
    for (int k = 28; k <= 29; k++) begin
      lp(6'(k), 16'h0040, 16'h0003, 1'h1);
      lp(6'(k), 16'h0000, 16'h0003, 1'h0);
      lp(6'(k), 16'h0040, 16'h0001, 1'h0);
    end
    $display("loop test done");
  endtask

  // Locked jump with both other prefixes, then the same jump unlocked
  task automatic t_lock();
    n = lock_cnt;
    setr(OFF_IP, 16'h1000);
    run(OP_JUMP_SHORT, 8'h02, 4'hE);
    chk(32'(lock_cnt - n), 32'h1);
    chkr(OFF_IP, 16'h1002);
    // Taken, idle, lock, override and repeat all recorded together
    chkr(OFF_STATUS, 16'h0039);
    n = lock_cnt;
    run(OP_JUMP_SHORT, 8'h02, 4'hC);
    chk(32'(lock_cnt - n), 32'h0);
    $display("lock test done");
  endtask

  task automatic stop_test();
    $display("comparisons %0d mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // Reset for 8 cycles, then the scenarios in turn
  initial begin
    repeat (8) @(posedge aclk);
    aresetn <= 1'h1;
    t_bus();
    t_branch();
    t_data();
    t_loop();
    t_lock();
    stop_test();
  end
endmodule // testbench
